/* File: src/cbdec_expand.sv */
// byte expander: header-coded zero runs and literal groups
// assumes bytes arrive with valid and are held until ready
`timescale 1ns/10ps
`default_nettype none
module cbdec_expand (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_clear,
   input wire logic i_bypass,
   input wire logic i_byte_valid,
   input wire logic [7:0] i_byte,
   output logic o_ready,
   output cbdec_pkg::cbdec_cell_s o_cell
);

   cbdec_pkg::cbdec_state_e state_ff, nxt_state;
   logic [2:0] cnt_ff, nxt_cnt;
   cbdec_pkg::cbdec_cell_s cell_ff, nxt_cell;
   logic [2:0] hdr_len;

   assign hdr_len = i_byte[cbdec_pkg::CBDEC_HDR_LEN_MSB:cbdec_pkg::CBDEC_HDR_LEN_LSB];

   // ==========================================================
   // next state
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_cell.data = cell_ff.data;
      nxt_cell.we = 1'b0;
      case (state_ff)
         cbdec_pkg::CBDEC_ST_HEADER: begin
            if (i_byte_valid && i_bypass) begin
               nxt_cell.data = i_byte;
               nxt_cell.we = 1'b1;
            end else if (i_byte_valid && i_byte[cbdec_pkg::CBDEC_HDR_RUN_BIT]) begin
               nxt_cnt = hdr_len;
               if (hdr_len != cbdec_pkg::CBDEC_LEN_ZERO) begin
                  nxt_state = cbdec_pkg::CBDEC_ST_RUN;
               end
            end else if (i_byte_valid) begin
               nxt_cnt = hdr_len;
               nxt_state = cbdec_pkg::CBDEC_ST_LITERAL;
            end
         end
         cbdec_pkg::CBDEC_ST_LITERAL: begin
            if (i_byte_valid) begin
               nxt_cell.data = i_byte;
               nxt_cell.we = 1'b1;
               nxt_cnt = cnt_ff - cbdec_pkg::CBDEC_LEN_ONE;
               if (cnt_ff == cbdec_pkg::CBDEC_LEN_ZERO) begin
                  nxt_state = cbdec_pkg::CBDEC_ST_HEADER;
               end
            end
         end
         cbdec_pkg::CBDEC_ST_RUN: begin
            nxt_cell.data = cbdec_pkg::CBDEC_FILL_BYTE;
            nxt_cell.we = 1'b1;
            nxt_cnt = cnt_ff - cbdec_pkg::CBDEC_LEN_ONE;
            if (cnt_ff == cbdec_pkg::CBDEC_LEN_ONE) begin
               nxt_state = cbdec_pkg::CBDEC_ST_HEADER;
            end
         end
         default: begin
            nxt_state = cbdec_pkg::CBDEC_ST_HEADER;
         end
      endcase
      if (i_clear) begin
         nxt_state = cbdec_pkg::CBDEC_ST_HEADER;
         nxt_cnt = cbdec_pkg::CBDEC_LEN_ZERO;
         nxt_cell.we = 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state_ff <= cbdec_pkg::CBDEC_ST_HEADER;
         cnt_ff <= cbdec_pkg::CBDEC_LEN_ZERO;
         cell_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         cell_ff <= nxt_cell;
      end
   end

   assign o_ready = (state_ff != cbdec_pkg::CBDEC_ST_RUN);
   assign o_cell = cell_ff;

   // ==========================================================
   // checks
   sequence s_run_step;
      state_ff == cbdec_pkg::CBDEC_ST_RUN && !i_clear;
   endsequence

   property p_run_fills;
      @(posedge i_clk) disable iff (i_reset)
      s_run_step |=> (o_cell.we && o_cell.data == cbdec_pkg::CBDEC_FILL_BYTE);
   endproperty
   a_run_fills: assert property (p_run_fills) else $error("zero run not written");

   property p_bypass_copy;
      @(posedge i_clk) disable iff (i_reset)
      (state_ff == cbdec_pkg::CBDEC_ST_HEADER && i_bypass && i_byte_valid && !i_clear)
         |=> (o_cell.we && o_cell.data == $past(i_byte));
   endproperty
   a_bypass_copy: assert property (p_bypass_copy) else $error("bypass byte altered");

   property p_stall_bounded;
      @(posedge i_clk) disable iff (i_reset)
      (!o_ready) [*7] |=> o_ready;
   endproperty
   a_stall_bounded: assert property (p_stall_bounded) else $error("expander stall too long");

endmodule
`default_nettype wire

/* File: src/cbdec_pkg.sv */
// package for the configuration bitstream decompressor
// assumes a system clock of 125 MHz and a link clock from the far party
package cbdec_pkg;

   // ==========================================================
   // configuration schemes
   typedef enum logic [1:0] {
      CBDEC_FAST_PASSIVE_PARALLEL = 2'b00,
      CBDEC_ACTIVE_SERIAL = 2'b01,
      CBDEC_PASSIVE_SERIAL = 2'b10,
      CBDEC_BOUNDARY_SCAN = 2'b11
   } cbdec_scheme_e;

   // ==========================================================
   // expander states
   typedef enum logic [1:0] {
      CBDEC_ST_HEADER = 2'b00,
      CBDEC_ST_LITERAL = 2'b01,
      CBDEC_ST_RUN = 2'b10
   } cbdec_state_e;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic [7:0] data;
      logic we;
   } cbdec_cell_s;

   typedef struct packed {
      cbdec_scheme_e scheme;
      logic compress;
      logic active;
   } cbdec_cfg_s;

   // ==========================================================
   // widths, fields, counts
   localparam int CBDEC_BYTE_W = 8;
   localparam int CBDEC_WORD_W = 32;
   localparam int CBDEC_CFG_W = 4;
   localparam logic [5:0] CBDEC_WORD_BITS = 6'h20;
   localparam logic [5:0] CBDEC_SERIAL_STEP = 6'h01;
   localparam logic [5:0] CBDEC_PARALLEL_STEP = 6'h08;
   localparam logic [2:0] CBDEC_WORD_BYTES = 3'h4;
   // last hold count: parallel compressed bytes stand four link clocks
   localparam logic [1:0] CBDEC_PAR_HOLD_LAST = 2'h3;
   localparam int CBDEC_HDR_RUN_BIT = 7;
   localparam int CBDEC_HDR_LEN_MSB = 2;
   localparam int CBDEC_HDR_LEN_LSB = 0;
   localparam logic [2:0] CBDEC_LEN_ZERO = 3'h0;
   localparam logic [2:0] CBDEC_LEN_ONE = 3'h1;
   localparam logic [7:0] CBDEC_FILL_BYTE = 8'h00;
   localparam logic [31:0] CBDEC_WORD_RESET = 32'h0000_0000;
   localparam logic [5:0] CBDEC_BITS_RESET = 6'h00;

endpackage

/* File: src/cbdec_sync.sv */
// three-stage level synchroniser
// assumes the input is a level held long enough to be seen twice
`timescale 1ns/10ps
`default_nettype none
module cbdec_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;
   logic [W-1:0] nxt_out;

   // ==========================================================
   // accept a value once stages two and three agree
   always_comb begin
      nxt_out = out_ff;
      if (s2_ff == s3_ff) begin
         nxt_out = s3_ff;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         out_ff <= '0;
      end else begin
         s1_ff <= i_async;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         out_ff <= nxt_out;
      end
   end

   assign o_level = out_ff;

endmodule
`default_nettype wire

/* File: src/cbdec_top.sv */
// configuration bitstream decompressor top
// Summary of operation
// - expand compressed stream on the fly into cells
// - decompress in parallel and serial, never boundary-scan
// - parallel chain shares one compression setting
// - serial devices choose compression individually
// - expansion outruns link, never stalls transfer
// assumes config_clock comes from the far party and stops outside frames
// assumes scheme and compression straps are steady during configuration
`timescale 1ns/10ps
`default_nettype none
module cbdec_top (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_config_clock,
   input wire logic [7:0] i_link_data,
   input wire logic [1:0] i_scheme,
   input wire logic i_compress_en,
   input wire logic i_config_active,
   output logic [7:0] o_cell_data,
   output logic o_cell_we,
   output logic o_decompress_on,
   output logic o_overrun
);

   // ==========================================================
   // strap synchronisers
   cbdec_pkg::cbdec_cfg_s cfg_raw;
   cbdec_pkg::cbdec_cfg_s cfg_sys;
   cbdec_pkg::cbdec_cfg_s cfg_lnk;
   logic [cbdec_pkg::CBDEC_CFG_W-1:0] cfg_sys_bits;
   logic [cbdec_pkg::CBDEC_CFG_W-1:0] cfg_lnk_bits;

   assign cfg_raw.scheme = cbdec_pkg::cbdec_scheme_e'(i_scheme);
   assign cfg_raw.compress = i_compress_en;
   assign cfg_raw.active = i_config_active;

   cbdec_sync #(
      .W(cbdec_pkg::CBDEC_CFG_W)
   ) u_sync_cfg_sys (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async(cfg_raw),
      .o_level(cfg_sys_bits)
   );

   cbdec_sync #(
      .W(cbdec_pkg::CBDEC_CFG_W)
   ) u_sync_cfg_lnk (
      .i_clk(i_config_clock),
      .i_reset(i_reset),
      .i_async(cfg_raw),
      .o_level(cfg_lnk_bits)
   );

   assign cfg_sys = cbdec_pkg::cbdec_cfg_s'(cfg_sys_bits);
   assign cfg_lnk = cbdec_pkg::cbdec_cfg_s'(cfg_lnk_bits);

   // ==========================================================
   // link side: gather words on config_clock
   logic [31:0] shift_ff, nxt_shift;
   logic [5:0] nbits_ff, nxt_nbits;
   logic [1:0] hold_ff, nxt_hold;
   logic [31:0] xfer_word_ff, nxt_xfer_word;
   logic xfer_tgl_ff, nxt_xfer_tgl;
   logic lnk_serial;
   logic lnk_parallel;
   logic lnk_take;
   logic [5:0] lnk_step;
   logic [5:0] lnk_sum;

   assign lnk_serial = (cfg_lnk.scheme == cbdec_pkg::CBDEC_ACTIVE_SERIAL) ||
                       (cfg_lnk.scheme == cbdec_pkg::CBDEC_PASSIVE_SERIAL);
   assign lnk_parallel = (cfg_lnk.scheme == cbdec_pkg::CBDEC_FAST_PASSIVE_PARALLEL);

   always_comb begin
      nxt_shift = shift_ff;
      nxt_nbits = nbits_ff;
      nxt_hold = hold_ff;
      nxt_xfer_word = xfer_word_ff;
      nxt_xfer_tgl = xfer_tgl_ff;
      lnk_take = 1'b0;
      lnk_step = cbdec_pkg::CBDEC_SERIAL_STEP;
      if (!cfg_lnk.active) begin
         nxt_nbits = cbdec_pkg::CBDEC_BITS_RESET;
         nxt_hold = '0;
      end else if (lnk_serial) begin
         lnk_take = 1'b1;
         nxt_shift = {i_link_data[0], shift_ff[31:1]};
      end else if (lnk_parallel) begin
         lnk_step = cbdec_pkg::CBDEC_PARALLEL_STEP;
         // compressed bytes stand four clocks; one sample per byte
         if (cfg_lnk.compress) begin
            lnk_take = (hold_ff == '0);
            nxt_hold = hold_ff + 2'h1;
            if (hold_ff == cbdec_pkg::CBDEC_PAR_HOLD_LAST) begin
               nxt_hold = '0;
            end
         end else begin
            lnk_take = 1'b1;
         end
         if (lnk_take) begin
            nxt_shift = {i_link_data, shift_ff[31:8]};
         end
      end
      lnk_sum = nbits_ff + lnk_step;
      if (lnk_take) begin
         nxt_nbits = lnk_sum;
         if (lnk_sum == cbdec_pkg::CBDEC_WORD_BITS) begin
            nxt_nbits = cbdec_pkg::CBDEC_BITS_RESET;
            nxt_xfer_word = nxt_shift;
            nxt_xfer_tgl = !xfer_tgl_ff;
         end
      end
   end

   always_ff @(posedge i_config_clock or posedge i_reset) begin
      if (i_reset) begin
         shift_ff <= cbdec_pkg::CBDEC_WORD_RESET;
         nbits_ff <= cbdec_pkg::CBDEC_BITS_RESET;
         hold_ff <= '0;
         xfer_word_ff <= cbdec_pkg::CBDEC_WORD_RESET;
         xfer_tgl_ff <= 1'b0;
      end else begin
         shift_ff <= nxt_shift;
         nbits_ff <= nxt_nbits;
         hold_ff <= nxt_hold;
         xfer_word_ff <= nxt_xfer_word;
         xfer_tgl_ff <= nxt_xfer_tgl;
      end
   end

   // ==========================================================
   // word crossing into the system clock
   logic tgl_sys;
   logic tgl_seen_ff, nxt_tgl_seen;
   logic word_arrive;

   cbdec_sync #(
      .W(1)
   ) u_sync_tgl (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_async(xfer_tgl_ff),
      .o_level(tgl_sys)
   );

   assign word_arrive = (tgl_sys != tgl_seen_ff);

   // ==========================================================
   // system side: unpack words into bytes
   logic [31:0] word_ff, nxt_word;
   logic [2:0] left_ff, nxt_left;
   logic bypass_ff, nxt_bypass;
   logic decomp_on_ff, nxt_decomp_on;
   logic overrun_ff, nxt_overrun;
   logic exp_ready;
   logic exp_valid;
   logic exp_clear;
   cbdec_pkg::cbdec_cell_s exp_cell;

   assign exp_valid = (left_ff != '0);
   assign exp_clear = !cfg_sys.active;

   always_comb begin
      nxt_tgl_seen = tgl_sys;
      nxt_word = word_ff;
      nxt_left = left_ff;
      nxt_overrun = overrun_ff;
      // one setting per device; boundary-scan never decompresses
      nxt_bypass = !cfg_sys.compress ||
                   (cfg_sys.scheme == cbdec_pkg::CBDEC_BOUNDARY_SCAN);
      nxt_decomp_on = !nxt_bypass;
      if (exp_valid && exp_ready) begin
         nxt_word = {8'h00, word_ff[31:8]};
         nxt_left = left_ff - 3'h1;
      end
      if (word_arrive) begin
         if (nxt_left != '0) begin
            nxt_overrun = 1'b1;
         end
         nxt_word = tgl_word_pick(xfer_word_ff);
         nxt_left = cbdec_pkg::CBDEC_WORD_BYTES;
      end
      if (exp_clear) begin
         nxt_left = '0;
         if (word_arrive) begin
            nxt_overrun = 1'b1;
         end else begin
            nxt_overrun = 1'b0;
         end
      end
   end

   // word is steady for several link clocks before its toggle is seen
   function automatic logic [31:0] tgl_word_pick(input logic [31:0] w);
      tgl_word_pick = w;
   endfunction

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         tgl_seen_ff <= 1'b0;
         word_ff <= cbdec_pkg::CBDEC_WORD_RESET;
         left_ff <= '0;
         bypass_ff <= 1'b1;
         decomp_on_ff <= 1'b0;
         overrun_ff <= 1'b0;
      end else begin
         tgl_seen_ff <= nxt_tgl_seen;
         word_ff <= nxt_word;
         left_ff <= nxt_left;
         bypass_ff <= nxt_bypass;
         decomp_on_ff <= nxt_decomp_on;
         overrun_ff <= nxt_overrun;
      end
   end

   // ==========================================================
   // expander writes the cells
   cbdec_expand u_expand (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_clear(exp_clear),
      .i_bypass(bypass_ff),
      .i_byte_valid(exp_valid),
      .i_byte(word_ff[7:0]),
      .o_ready(exp_ready),
      .o_cell(exp_cell)
   );

   assign o_cell_data = exp_cell.data;
   assign o_cell_we = exp_cell.we;
   assign o_decompress_on = decomp_on_ff;
   assign o_overrun = overrun_ff;

   // ==========================================================
   // checks
   property p_scan_no_decomp;
      @(posedge i_clk) disable iff (i_reset)
      (cfg_sys.scheme == cbdec_pkg::CBDEC_BOUNDARY_SCAN) |=> !o_decompress_on;
   endproperty
   a_scan_no_decomp: assert property (p_scan_no_decomp) else $error("decompress in scan");

   property p_serial_select;
      @(posedge i_clk) disable iff (i_reset)
      (cfg_sys.scheme != cbdec_pkg::CBDEC_BOUNDARY_SCAN)
         |=> (o_decompress_on == $past(cfg_sys.compress));
   endproperty
   a_serial_select: assert property (p_serial_select) else $error("per device select lost");

   sequence s_par_take;
      lnk_take && lnk_parallel && cfg_lnk.compress && cfg_lnk.active;
   endsequence

   property p_par_spacing;
      @(posedge i_config_clock) disable iff (i_reset)
      s_par_take ##1 (lnk_parallel && cfg_lnk.compress && cfg_lnk.active) |-> !lnk_take [*3];
   endproperty
   a_par_spacing: assert property (p_par_spacing) else $error("parallel sample spacing wrong");

endmodule
`default_nettype wire

/* File: testbench/cbdec_host_model.sv */
// far-side host model: drives config_clock and link data for whole words
// assumes the bench calls its tasks; clock stands still low between frames
`timescale 1ns/10ps
`default_nettype none
module cbdec_host_model (
   output logic o_config_clock,
   output logic [7:0] o_link_data
);
   // ==========================================================
   // link timing
   localparam realtime HALF = 7.5;

   initial begin
      o_config_clock = 1'b0;
      o_link_data = 8'h00;
   end

   // one link clock, data set up before the rising edge and held across it
   task automatic pulse(input logic [7:0] d);
      o_link_data = d;
      #(HALF);
      o_config_clock = 1'b1;
      #(HALF);
      o_config_clock = 1'b0;
   endtask

   // ==========================================================
   // idle clocks with a changing pattern
   task automatic preamble(input int n);
      int i;
      #1.3;
      for (i = 0; i < n; i++) begin
         pulse(~o_link_data);
      end
      o_link_data = ~o_link_data;
   endtask

   // ==========================================================
   // one 32-bit word, low byte first; serial sends bit 0 first
   task automatic send_word(input logic [31:0] w, input logic par, input logic comp);
      int i;
      int r;
      #1.3;
      if (par) begin
         for (i = 0; i < 4; i++) begin
            for (r = 0; r < (comp ? 4 : 1); r++) begin
               pulse(w[8*i +: 8]);
            end
         end
      end else begin
         for (i = 0; i < 32; i++) begin
            pulse({~o_link_data[7:1], w[i]});
         end
      end
      o_link_data = ~o_link_data;
   endtask
endmodule
`default_nettype wire

/* File: testbench/tb_cbdec_top.sv */
// self-checking bench for the decompressor top
// assumes cbdec_pkg and the host model are compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_cbdec_top;
   // ==========================================================
   // signals
   logic i_clk;
   logic i_reset;
   logic i_config_clock;
   logic [7:0] i_link_data;
   logic [1:0] i_scheme;
   logic i_compress_en;
   logic i_config_active;
   logic [7:0] o_cell_data;
   logic o_cell_we;
   logic o_decompress_on;
   logic o_overrun;
   int n_mismatch = 0;
   int n_checks = 0;
   int seed = 32'h4453;
   logic [7:0] exp_q[$];

   cbdec_top cbdec_top_i (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_config_clock(i_config_clock),
      .i_link_data(i_link_data),
      .i_scheme(i_scheme),
      .i_compress_en(i_compress_en),
      .i_config_active(i_config_active),
      .o_cell_data(o_cell_data),
      .o_cell_we(o_cell_we),
      .o_decompress_on(o_decompress_on),
      .o_overrun(o_overrun)
   );

   cbdec_host_model cbdec_host_model_i (
      .o_config_clock(i_config_clock),
      .o_link_data(i_link_data)
   );

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   // ==========================================================
   // compare tasks and verdict
   task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic check_flag(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ==========================================================
   // result watcher: every cell write takes the oldest note
   always @(posedge i_clk) begin
      if (o_cell_we === 1'b1) begin
         if (exp_q.size() == 0) begin
            check_flag("cell write without note", 1'b0, 1'b1);
         end else begin
            check_byte("cell data", exp_q.pop_front(), o_cell_data);
         end
      end
   end

   // ==========================================================
   // one configuration session of several words
   task automatic session(input logic [1:0] sch, input logic comp, input int nw);
      logic [31:0] w;
      logic bs;
      int k;
      int j;
      int t;
      bs = (sch == cbdec_pkg::CBDEC_BOUNDARY_SCAN);
      @(posedge i_clk);
      i_scheme <= sch;
      i_compress_en <= comp;
      repeat (8) @(posedge i_clk);
      // link clocks with intake idle: straps reach the link side, word count clears
      cbdec_host_model_i.preamble(8);
      @(posedge i_clk);
      i_config_active <= 1'b1;
      repeat (8) @(posedge i_clk);
      // link side sees active on the fourth clock; data starts on the fifth
      cbdec_host_model_i.preamble(4);
      for (k = 0; k < nw; k++) begin
         w = $random(seed);
         if (!bs && comp) begin
            // zero run header, literal header for two bytes, two literals
            w = {w[31:16], 1'b0, w[13:10], 3'h1, 1'b1, w[6:0]};
            for (j = 0; j < int'(w[2:0]); j++) begin
               exp_q.push_back(cbdec_pkg::CBDEC_FILL_BYTE);
            end
            exp_q.push_back(w[23:16]);
            exp_q.push_back(w[31:24]);
         end else if (!bs) begin
            for (j = 0; j < 4; j++) begin
               exp_q.push_back(w[8*j +: 8]);
            end
         end
         cbdec_host_model_i.send_word(w, sch == cbdec_pkg::CBDEC_FAST_PASSIVE_PARALLEL, comp);
      end
      for (t = 0; t < 300 && exp_q.size() > 0; t++) begin
         @(posedge i_clk);
      end
      if (exp_q.size() > 0) begin
         n_mismatch++;
         $display("unexpected pending cell writes: expected 0 seen %0d", exp_q.size());
         exp_q.delete();
      end
      repeat (4) @(posedge i_clk);
      check_flag("decompress on", comp && !bs, o_decompress_on);
      check_flag("overrun", 1'b0, o_overrun);
      i_config_active <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      i_reset = 1'b1;
      i_scheme = cbdec_pkg::CBDEC_PASSIVE_SERIAL;
      i_compress_en = 1'b0;
      i_config_active = 1'b0;
      cbdec_host_model_i.preamble(4);
      repeat (16) @(posedge i_clk);
      i_reset <= 1'b0;
      repeat (8) @(posedge i_clk);
      check_flag("decompress on after reset", 1'b0, o_decompress_on);
      session(cbdec_pkg::CBDEC_PASSIVE_SERIAL, 1'b0, 6);
      session(cbdec_pkg::CBDEC_PASSIVE_SERIAL, 1'b1, 6);
      session(cbdec_pkg::CBDEC_ACTIVE_SERIAL, 1'b1, 6);
      session(cbdec_pkg::CBDEC_ACTIVE_SERIAL, 1'b0, 6);
      session(cbdec_pkg::CBDEC_FAST_PASSIVE_PARALLEL, 1'b1, 8);
      session(cbdec_pkg::CBDEC_FAST_PASSIVE_PARALLEL, 1'b0, 8);
      session(cbdec_pkg::CBDEC_BOUNDARY_SCAN, 1'b1, 3);
      tally_and_finish();
   end
endmodule
`default_nettype wire
